// ---- dsfs_master_model.sv ----
`timescale 1ns/1ns
module dsfs_master_model (
   // Clock.
   input  wire logic        mclk,
   // Register requests.
   output logic      [15:0] reg_addr,
   output logic             reg_rd,
   output logic             reg_wr,
   output logic      [31:0] reg_wdata
);
   initial begin
      reg_addr  = 16'h0000;
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   // One request per call; idle address and data are inverted, strobes go low, so a stale value never decodes.
   task automatic xfer(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(negedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_rd    <= ~wr;
      reg_wr    <= wr;
      @(negedge mclk);
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      reg_addr  <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

// ---- dsfs_pkg.sv ----
package dsfs_pkg;
   localparam int CLK_HZ      = 100_000_000;
   localparam int T_TICK_S    = 1;
   localparam int SEC_PER_MIN = 60;

   typedef logic        [10:0] dsfs_sec_t;
   typedef logic signed [10:0] dsfs_ana_t;

   localparam logic [15:0] REG_NORMAL  = 16'h9cb9;
   localparam logic [15:0] REG_DERATE  = 16'h9cbb;
   localparam logic [15:0] REG_SAFE    = 16'h9cbd;
   localparam logic [15:0] REG_ALARM   = 16'h9cbf;
   localparam logic [15:0] REG_REBOOT  = 16'h9cc7;
   localparam logic [15:0] REG_TIMEOUT = 16'h9cd4;
   localparam logic [15:0] REG_EXT_AMB = 16'h9d21;

   localparam int NB_RUN = 0, NB_HEAT = 3, NB_START = 4, NB_OIL = 5;
   localparam int NB_RESTART = 6, NB_DERATE = 28, NB_SAFE = 29;
   localparam int NB_ALARM = 30, NB_TRIP = 31;
   localparam int DB_PST = 0, DB_SUC = 2, DB_CPL = 4, DB_CPH = 5, DB_PWR = 6;
   localparam int SB_EVI = 0, SB_EVO = 1, SB_AMB = 2, SB_AGE = 3, NSAFE = 3;
   localparam int AB_PERIPH = 0, AB_ENV = 1, AB_OVC = 2, AB_DCH = 3;
   localparam int AB_DRT = 4, AB_UV = 5, AB_DIS = 6, AB_DISINV = 7;
   localparam int AB_COMM = 8, AB_MCP = 9, AB_DCL = 10, AB_SUCINV = 11;
   localparam int AB_CPINV = 12, AB_CPLOW = 13, AB_DEF = 14, AB_FREQ = 15;
   localparam int AB_INT = 31, NALM = 16;

   localparam logic [15:0] FIXED_RPM = 16'h0960;
   localparam logic [15:0] ZERO_RPM  = 16'h0000;

   localparam dsfs_sec_t T_START_S   = 11'h03c;
   localparam dsfs_sec_t T_OIL_S     = 11'h03c;
   localparam int        T_LOW_MIN   = 30;
   localparam dsfs_sec_t T_LOW_S     = dsfs_sec_t'(T_LOW_MIN * SEC_PER_MIN);
   localparam dsfs_sec_t T_RESTART_S = 11'h03c;
   localparam dsfs_sec_t T_SAFE_S    = 11'h03c;
   localparam dsfs_sec_t T_AGE_S     = 11'h03c;
   localparam dsfs_sec_t T_ENV_A_S   = 11'h03c;
   localparam dsfs_sec_t T_ENV_B_S   = 11'h05a;
   localparam dsfs_sec_t T_ALM_S     = 11'h078;
   localparam int        T_COMM_MIN  = 2;
   localparam dsfs_sec_t T_COMM_S    = dsfs_sec_t'(T_COMM_MIN * SEC_PER_MIN);
   localparam dsfs_sec_t T_DEF_S     = 11'h708;
   localparam dsfs_sec_t T_FREQ_S    = 11'h258;

   localparam logic [3:0] N_TRIP10 = 4'ha;
   localparam logic [3:0] N_OVC    = 4'h5;
   localparam logic [2:0] N_STOPS  = 3'h6;

   localparam dsfs_ana_t V_SUP_DER = 11'sh0d0;
   localparam dsfs_ana_t V_SUP_UV  = 11'sh0b4;
   localparam dsfs_ana_t V_DCL_HI  = 11'sh1c2;
   localparam dsfs_ana_t V_DCL_LO  = 11'sh0c8;
   localparam dsfs_ana_t T_DRV_HI  = 11'sh073;
   localparam dsfs_ana_t T_DIS_HI  = 11'sh08a;
   localparam dsfs_ana_t T_DIS_MIN = -11'sh03c;
   localparam dsfs_ana_t T_DIS_MAX = 11'sh0c8;
   localparam dsfs_ana_t T_AMB_MIN = -11'sh03c;
   localparam dsfs_ana_t T_AMB_MAX = 11'sh064;
   localparam dsfs_ana_t P_MIN     = 11'sh000;
   localparam dsfs_ana_t P_SUC_MAX = 11'sh0a0;
   localparam dsfs_ana_t P_CON_MAX = 11'sh1f4;

   typedef enum logic [1:0] {
      RUN_STOP  = 2'b00,
      RUN_START = 2'b01,
      RUN_RUN   = 2'b11,
      RUN_OIL   = 2'b10
   } dsfs_run_e;

   typedef struct packed {
      logic        turning;
      logic        heater;
      logic        pst_crit;
      logic        suc_low;
      logic        cond_low;
      logic        cond_high;
      logic        extreme;
      logic        ac_fan;
      logic        evc_in_lost;
      logic        evc_out_lost;
      logic        ext_sel;
      logic        env_out;
      logic        env_long;
      logic        env_suc;
      logic        ovc;
      logic        earth;
      logic        mcp_fault;
      logic        int_err;
      logic        defrost;
      logic        cond_low_run;
      logic [15:0] speed_ref;
      dsfs_ana_t   supply_v;
      dsfs_ana_t   dclink_v;
      dsfs_ana_t   drive_t;
      dsfs_ana_t   discharge_temp_sensor;
      dsfs_ana_t   amb_t;
      dsfs_ana_t   suction_pressure;
      dsfs_ana_t   condenser_pressure;
   } dsfs_sens_t;
endpackage

// ---- dsfs_supervisor.sv ----
`timescale 1ns/1ns
// Summary of operation
// - Running flag follows compressor rotation.
// - Start-up holds 2400 RPM for 60 s.
// - Oil return after 30 min below 2400.
// - Restart blocked 60 s after stop.
// - Summary flags in normal word bits 28-31.
// - Power stage hot sets derate, slows.
// - Suction low, condenser high derate speed.
// - Condenser low reduces fan, AC only.
// - Supply below 208 V limits power.
// - Valve controller loss held 60 s.
// - Ambient out of range held 60 s.
// - External ambient stale 60 s flags.
// - Several safe conditions raise alarm.
// - Envelope alarm; ten low-suction ones trip.
// - Overcurrent stops; earth fault trips.
// - DC link over 450 V; ten trip.
// - Drive over 115 C trips at once.
// - Supply below 180 V stops compressor.
// - Discharge over 138 C; ten trip.
// - Invalid sensor readings stop the drive.
// - Read timeout stops; resume 2 min later.
// - Safety or internal error trips at once.
// - Alarm bits stay set 120 s.
// - Trip lock cleared by power or reboot.
// - Status bit set while condition present.
module dsfs_supervisor
   import dsfs_pkg::*;
#(
   parameter int SEC_CYCLES = CLK_HZ * T_TICK_S
) (
   // Clock and resets.
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        por,
   // Sensor and drive condition pins.
   input  wire dsfs_sens_t  sens,
   // Register port of the thermostat master.
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] rd_data,
   output logic             rd_valid,
   output logic             rd_err,
   // Drive commands.
   output logic      [15:0] speed_cmd,
   output logic             run_en,
   output logic             fan_reduce,
   output logic             pwr_limit
);

   typedef struct packed {
      logic [31:0]                div;
      logic                       tick;
      logic [1:0]                 fill;
      dsfs_sens_t                 s1;
      dsfs_sens_t                 s2;
      dsfs_run_e                  run;
      dsfs_sec_t                  run_t;
      dsfs_sec_t                  low_t;
      dsfs_sec_t                  restart_t;
      logic [NALM-1:0][10:0]      ahold;
      logic [NSAFE-1:0][10:0]     shold;
      logic [NALM-1:0]            araw_q;
      dsfs_sec_t                  env_t;
      dsfs_sec_t                  def_t;
      dsfs_sec_t                  age_t;
      dsfs_sec_t                  freq_t;
      logic [2:0]                 stops;
      logic [15:0]                tmo_s;
      logic [15:0]                comm_t;
      logic                       comm_lost;
      dsfs_sec_t                  comm_rec;
      dsfs_ana_t                  ext_amb;
      logic [31:0]                rd_data;
      logic                       rd_valid;
      logic                       rd_err;
      logic [15:0]                speed_cmd;
      logic                       run_en;
      logic                       fan_reduce;
      logic                       pwr_limit;
   } dsfs_st_t;

   typedef struct packed {
      logic [31:0] cause;
      logic [3:0]  n_env;
      logic [3:0]  n_dch;
      logic [3:0]  n_dis;
      logic [3:0]  n_cpl;
      logic [3:0]  n_ovc;
   } dsfs_trip_t;

   function automatic logic out_rng(dsfs_ana_t v, dsfs_ana_t lo, dsfs_ana_t hi);
      return (v < lo) || (v > hi);
   endfunction
   function automatic dsfs_sec_t sat_inc(dsfs_sec_t v, dsfs_sec_t lim);
      return (v >= lim) ? lim : dsfs_sec_t'(v + 11'h001);
   endfunction
   dsfs_st_t        q;
   dsfs_st_t        next_q;
   dsfs_trip_t      tp;
   dsfs_trip_t      next_tp;
   dsfs_sens_t      s;
   dsfs_ana_t       amb;
   logic [NSAFE:0]  sraw;
   logic [31:0]     norm_w;
   logic [31:0]     der_w;
   logic [31:0]     safe_w;
   logic [31:0]     alm_w;
   logic [NALM-1:0] araw;
   logic [NALM-1:0] rise;
   logic [31:0]     tev;
   dsfs_sec_t       env_lim;
   logic            stop_req;
   logic            reboot;

   assign s      = q.s2;
   assign amb    = s.ext_sel ? q.ext_amb : s.amb_t;
   assign reboot = reg_wr && (reg_addr == REG_REBOOT);
   assign sraw[SB_EVI] = s.evc_in_lost;
   assign sraw[SB_EVO] = s.evc_out_lost;
   assign sraw[SB_AMB] = out_rng(amb, T_AMB_MIN, T_AMB_MAX);
   assign sraw[SB_AGE] = s.ext_sel && (q.age_t >= T_AGE_S);
   // Safe-mode bits other than SB_AGE stretch past the end of their cause.
   generate
      for (genvar i = 0; i < NSAFE; i++) begin : g_safe
         assign safe_w[i] = sraw[i] || (q.shold[i] != 11'h000);
      end
   endgenerate
   assign safe_w[SB_AGE]   = sraw[SB_AGE];
   assign safe_w[31:NSAFE+1] = '0;
   assign der_w = (32'h1 << DB_PST) * s.pst_crit
                | (32'h1 << DB_SUC) * s.suc_low
                | (32'h1 << DB_CPL) * (s.cond_low && s.ac_fan)
                | (32'h1 << DB_CPH) * s.cond_high
                | (32'h1 << DB_PWR) * ((s.supply_v < V_SUP_DER) || s.extreme);
   assign env_lim = s.env_long ? T_ENV_B_S : T_ENV_A_S;
   always_comb begin
      araw            = '0;
      araw[AB_PERIPH] = |(safe_w & (safe_w - 32'h1));
      araw[AB_ENV]    = s.env_out && (q.env_t >= env_lim);
      araw[AB_OVC]    = s.ovc;
      araw[AB_DCH]    = s.dclink_v > V_DCL_HI;
      araw[AB_DRT]    = s.drive_t > T_DRV_HI;
      araw[AB_UV]     = s.supply_v < V_SUP_UV;
      araw[AB_DIS]    = s.discharge_temp_sensor > T_DIS_HI;
      araw[AB_DISINV] = out_rng(s.discharge_temp_sensor, T_DIS_MIN, T_DIS_MAX);
      araw[AB_COMM]   = q.comm_lost;
      araw[AB_MCP]    = s.mcp_fault;
      araw[AB_DCL]    = s.dclink_v < V_DCL_LO;
      araw[AB_SUCINV] = out_rng(s.suction_pressure, P_MIN, P_SUC_MAX);
      araw[AB_CPINV]  = out_rng(s.condenser_pressure, P_MIN, P_CON_MAX);
      araw[AB_CPLOW]  = s.cond_low_run && (q.run == RUN_RUN);
      araw[AB_DEF]    = q.def_t >= T_DEF_S;
      araw[AB_FREQ]   = q.stops >= N_STOPS;
      // Zeroed synchroniser stages after reset would read as undervoltage, so wait for samples.
      araw            = araw & {NALM{q.fill[1]}};
   end
   assign rise = araw & ~q.araw_q;
   // Alarm bits hold for the minimum time after their cause clears.
   generate
      for (genvar i = 0; i < NALM; i++) begin : g_alm
         assign alm_w[i] = araw[i] || (q.ahold[i] != 11'h000) || tp.cause[i];
      end
   endgenerate
   assign alm_w[30:NALM] = tp.cause[30:NALM];
   assign alm_w[AB_INT]  = tp.cause[AB_INT];
   always_comb begin
      tev          = '0;
      tev[AB_ENV]  = rise[AB_ENV] && s.env_suc && (tp.n_env == N_TRIP10 - 4'h1);
      tev[AB_OVC]  = rise[AB_OVC] && (s.earth || (tp.n_ovc == N_OVC - 4'h1));
      tev[AB_DCH]  = rise[AB_DCH] && (tp.n_dch == N_TRIP10 - 4'h1);
      tev[AB_DRT]  = araw[AB_DRT];
      tev[AB_DIS]  = rise[AB_DIS] && (tp.n_dis == N_TRIP10 - 4'h1);
      tev[AB_MCP]  = araw[AB_MCP];
      tev[AB_CPLOW] = rise[AB_CPLOW] && (tp.n_cpl == N_TRIP10 - 4'h1);
      tev[AB_DEF]  = araw[AB_DEF];
      tev[AB_FREQ] = araw[AB_FREQ];
      tev[AB_INT]  = s.int_err;
   end

   assign norm_w = (32'h1 << NB_RUN) * s.turning
                 | (32'h1 << NB_HEAT) * s.heater
                 | (32'h1 << NB_START) * (q.run == RUN_START)
                 | (32'h1 << NB_OIL) * (q.run == RUN_OIL)
                 | (32'h1 << NB_RESTART) * ((q.run == RUN_STOP) && (q.restart_t < T_RESTART_S))
                 | (32'h1 << NB_DERATE) * (|der_w)
                 | (32'h1 << NB_SAFE) * (|safe_w)
                 | (32'h1 << NB_ALARM) * (|alm_w)
                 | (32'h1 << NB_TRIP) * (|tp.cause);

   assign stop_req = (|alm_w) || (s.speed_ref == ZERO_RPM);

   always_comb begin
      next_q      = q;
      next_q.s1   = sens;
      next_q.s2   = q.s1;
      next_q.fill = {q.fill[0], 1'b1};
      next_q.tick = 1'b0;
      next_q.div  = q.div + 32'h1;
      if (q.div >= 32'(SEC_CYCLES - 1)) begin
         next_q.div  = '0;
         next_q.tick = 1'b1;
      end
      next_q.araw_q = araw;
      for (int i = 0; i < NALM; i++) begin
         if (araw[i]) begin
            next_q.ahold[i] = T_ALM_S;
         end else if (q.tick && (q.ahold[i] != 11'h000)) begin
            next_q.ahold[i] = q.ahold[i] - 11'h001;
         end
      end
      for (int i = 0; i < NSAFE; i++) begin
         if (sraw[i]) begin
            next_q.shold[i] = T_SAFE_S;
         end else if (q.tick && (q.shold[i] != 11'h000)) begin
            next_q.shold[i] = q.shold[i] - 11'h001;
         end
      end
      if (q.tick) begin
         next_q.env_t     = s.env_out ? sat_inc(q.env_t, T_ENV_B_S) : 11'h000;
         next_q.def_t     = s.defrost ? sat_inc(q.def_t, T_DEF_S) : 11'h000;
         next_q.age_t     = sat_inc(q.age_t, T_AGE_S);
         next_q.restart_t = sat_inc(q.restart_t, T_RESTART_S);
         next_q.run_t     = sat_inc(q.run_t, T_LOW_S);
         next_q.comm_t    = (q.comm_t == 16'hffff) ? q.comm_t : q.comm_t + 16'h1;
         next_q.comm_rec  = sat_inc(q.comm_rec, T_COMM_S);
         if ((q.run == RUN_RUN) && (q.speed_cmd < FIXED_RPM)) begin
            next_q.low_t = sat_inc(q.low_t, T_LOW_S);
         end else begin
            next_q.low_t = 11'h000;
         end
         if (q.stops != 3'h0) begin
            next_q.freq_t = sat_inc(q.freq_t, T_FREQ_S);
         end
      end
      if (q.freq_t >= T_FREQ_S) begin
         next_q.stops  = 3'h0;
         next_q.freq_t = 11'h000;
      end
      if (reg_wr && (reg_addr == REG_TIMEOUT)) begin
         next_q.tmo_s = reg_wdata[15:0];
      end
      if (reg_wr && (reg_addr == REG_EXT_AMB)) begin
         next_q.ext_amb = reg_wdata[10:0];
         next_q.age_t   = 11'h000;
      end
      if (reg_rd) begin
         next_q.comm_t = 16'h0;
      end
      // Recovery time runs only while reads arrive within the timeout.
      if (q.comm_lost && (q.comm_rec >= T_COMM_S)) begin
         next_q.comm_lost = 1'b0;
      end
      if (q.tmo_s == 16'h0) begin
         next_q.comm_lost = 1'b0;
      end else if (q.comm_t >= q.tmo_s) begin
         next_q.comm_lost = 1'b1;
         next_q.comm_rec  = 11'h000;
      end
      unique case (q.run)
         RUN_STOP: begin
            if (!stop_req && (q.restart_t >= T_RESTART_S)) begin
               next_q.run   = RUN_START;
               next_q.run_t = 11'h000;
            end
         end
         RUN_START: begin
            if (q.run_t >= T_START_S) begin
               next_q.run   = RUN_RUN;
               next_q.low_t = 11'h000;
            end
         end
         RUN_RUN: begin
            if (q.low_t >= T_LOW_S) begin
               next_q.run   = RUN_OIL;
               next_q.run_t = 11'h000;
            end
         end
         RUN_OIL: begin
            if (q.run_t >= T_OIL_S) begin
               next_q.run   = RUN_RUN;
               next_q.low_t = 11'h000;
            end
         end
      endcase
      if (stop_req && (q.run != RUN_STOP)) begin
         next_q.run       = RUN_STOP;
         next_q.restart_t = 11'h000;
         if (q.stops < N_STOPS) begin
            next_q.stops = q.stops + 3'h1;
         end
      end
      if ((next_q.run == RUN_START) || (next_q.run == RUN_OIL) || (|safe_w)) begin
         next_q.speed_cmd = FIXED_RPM;
      end else if (s.pst_crit || s.suc_low || s.cond_high) begin
         next_q.speed_cmd = {1'b0, s.speed_ref[15:1]};
      end else begin
         next_q.speed_cmd = s.speed_ref;
      end
      if (next_q.run == RUN_STOP) begin
         next_q.speed_cmd = ZERO_RPM;
      end
      next_q.run_en     = next_q.run != RUN_STOP;
      next_q.fan_reduce = der_w[DB_CPL];
      next_q.pwr_limit  = der_w[DB_PWR];
      next_q.rd_valid   = reg_rd;
      next_q.rd_err     = 1'b0;
      next_q.rd_data    = '0;
      if (reg_rd) begin
         unique case (reg_addr)
            REG_NORMAL:  next_q.rd_data = norm_w;
            REG_DERATE:  next_q.rd_data = der_w;
            REG_SAFE:    next_q.rd_data = safe_w;
            REG_ALARM:   next_q.rd_data = alm_w;
            REG_TIMEOUT: next_q.rd_data = {16'h0, q.tmo_s};
            default:     next_q.rd_err = 1'b1;
         endcase
      end
   end

   always_comb begin
      next_tp = tp;
      if (reboot) begin
         next_tp = '0;
      end
      if (rise[AB_ENV]) begin
         next_tp.n_env = s.env_suc ? next_tp.n_env + 4'h1 : 4'h0;
      end
      if (rise[AB_OVC]) begin
         next_tp.n_ovc = next_tp.n_ovc + 4'h1;
      end
      if (rise[AB_DCH]) begin
         next_tp.n_dch = next_tp.n_dch + 4'h1;
      end
      if (rise[AB_DIS]) begin
         next_tp.n_dis = next_tp.n_dis + 4'h1;
      end
      if (rise[AB_CPLOW]) begin
         next_tp.n_cpl = next_tp.n_cpl + 4'h1;
      end
      next_tp.cause = next_tp.cause | tev;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // Trip lock state ignores the ordinary reset.
   always_ff @(posedge mclk or posedge por) begin
      if (por) begin
         tp <= '0;
      end else begin
         tp <= next_tp;
      end
   end

   assign rd_data    = q.rd_data;
   assign rd_valid   = q.rd_valid;
   assign rd_err     = q.rd_err;
   assign speed_cmd  = q.speed_cmd;
   assign run_en     = q.run_en;
   assign fan_reduce = q.fan_reduce;
   assign pwr_limit  = q.pwr_limit;

   sequence s_start_entry;
      (q.run == RUN_STOP) ##1 (q.run == RUN_START);
   endsequence

   a_running_flag: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && (reg_addr == REG_NORMAL) && q.s2.turning |=> rd_data[NB_RUN]) else $error("running flag wrong");
   a_startup_speed: assert property (@(posedge mclk) disable iff (rst)
      s_start_entry |-> (q.speed_cmd == FIXED_RPM)) else $error("start speed wrong");
   a_oil_entry: assert property (@(posedge mclk) disable iff (rst)
      (q.run == RUN_RUN) && (q.low_t >= T_LOW_S) && !stop_req |=> (q.run == RUN_OIL))
      else $error("oil return missed");
   a_restart_block: assert property (@(posedge mclk) disable iff (rst)
      (q.run == RUN_STOP) && (q.restart_t < T_RESTART_S) |=> (q.run == RUN_STOP))
      else $error("restart too early");
   a_alarm_summary: assert property (@(posedge mclk) disable iff (rst)
      reg_rd && (reg_addr == REG_NORMAL) && (|alm_w) |=> rd_data[NB_ALARM]) else $error("alarm summary wrong");
   a_alarm_hold: assert property (@(posedge mclk) disable iff (rst)
      $fell(araw[AB_UV]) |-> alm_w[AB_UV] [*8]) else $error("alarm dropped early");
   a_trip_stops: assert property (@(posedge mclk) disable iff (rst || por)
      (tp.cause != 32'h0) |=> !q.run_en && (q.speed_cmd == ZERO_RPM))
      else $error("trip lock did not stop");
   a_temp_trip: assert property (@(posedge mclk) disable iff (rst || por)
      (q.s2.drive_t > T_DRV_HI) && !reboot |=> tp.cause[AB_DRT]) else $error("no trip");
   a_multi_safe: assert property (@(posedge mclk) disable iff (rst)
      safe_w[SB_EVI] && safe_w[SB_EVO] |-> alm_w[AB_PERIPH]) else $error("no alarm");
endmodule

// ---- test_dsfs_supervisor.sv ----
`timescale 1ns/1ns
module test_dsfs_supervisor;
   import dsfs_pkg::*;
   localparam int SC   = 10;
   localparam int CEIL = 40000;
   typedef struct {string nm; logic [31:0] msk; logic [31:0] ex; logic er;} dsfs_note_t;
   logic        mclk, rst, por, reg_rd, reg_wr, rd_valid, rd_err;
   logic        run_en, fan_reduce, pwr_limit;
   logic [15:0] reg_addr, speed_cmd, sref;
   logic [31:0] reg_wdata, rd_data;
   dsfs_sens_t  sens;
   dsfs_note_t  nq[$];
   dsfs_note_t  n;
   int          error_cnt, n_checks, cyc, k, seed;
   int          dpos[5] = '{DB_PST, DB_SUC, DB_CPH, DB_CPL, DB_PWR};

   dsfs_supervisor #(.SEC_CYCLES(SC)) u_dut (
      .mclk(mclk), .rst(rst), .por(por), .sens(sens),
      .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err), .speed_cmd(speed_cmd),
      .run_en(run_en), .fan_reduce(fan_reduce), .pwr_limit(pwr_limit));
   dsfs_master_model u_m (.mclk(mclk), .reg_addr(reg_addr), .reg_rd(reg_rd),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic rq(input string nm, input logic [15:0] a, input logic [31:0] m,
                     input logic [31:0] e, input logic er = 1'b0);
      nq.push_back('{nm, m, e, er});
      u_m.xfer(1'b0, a, 32'h0000_0000);
   endtask
   task automatic tick(input int c);
      repeat (c) @(negedge mclk);
   endtask
   task automatic wait_spd(input logic [15:0] v, input int lim);
      k = 0;
      while (speed_cmd !== v && k < lim) begin
         @(negedge mclk);
         k++;
      end
   endtask
   task automatic set_der(input int i, input logic v);
      case (i)
         0: sens.pst_crit = v;
         1: sens.suc_low = v;
         2: sens.cond_high = v;
         3: sens.cond_low = v;
         default: sens.supply_v = v ? 11'sh0c8 : 11'sh0e6;
      endcase
      sens.ac_fan = v && (i == 3);
   endtask

   // Each read answer is matched against the oldest expectation.
   always @(negedge mclk) begin
      if (rd_valid === 1'b1) begin
         if (nq.size() == 0) begin
            chk("spare answer", 32'h1, 32'h0);
         end else begin
            n = nq.pop_front();
            chk(n.nm, n.ex, rd_data & n.msk);
            chk({n.nm, " err"}, {31'h0, n.er}, {31'h0, rd_err});
         end
      end
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == CEIL) begin
         error_cnt++;
         report_and_stop();
      end
   end

   initial begin
      seed = 2549;
      rst = 1'b1;
      por = 1'b1;
      sens = '0;
      sens.supply_v = 11'sh0e6;
      sens.dclink_v = 11'sh12c;
      sens.drive_t = 11'sh028;
      sens.discharge_temp_sensor = 11'sh03c;
      sens.amb_t = 11'sh014;
      sens.suction_pressure = 11'sh032;
      sens.condenser_pressure = 11'sh096;
      sref = 16'h0bb8 + (16'($random(seed)) & 16'h03ff);
      sens.speed_ref = sref;
      tick(7);
      rst = 1'b0;
      por = 1'b0;
      tick(5);
      rq("alarm", REG_ALARM, 32'hffff_ffff, 32'h0);
      rq("safe", REG_SAFE, 32'hffff_ffff, 32'h0);
      rq("derate", REG_DERATE, 32'hffff_ffff, 32'h0);
      rq("hole", 16'h9cba, 32'hffff_ffff, 32'h0, 1'b1);
      rq("normal", REG_NORMAL, 32'hf000_0041, 32'h0000_0040);
      sens.turning = 1'b1;
      tick(5);
      rq("running", REG_NORMAL, 32'h1, 32'h1);
      $display("test reset done");
      k = 0;
      while (run_en !== 1'b1 && k < 900) begin
         @(negedge mclk);
         k++;
      end
      chk("restart wait", 32'h1, 32'(k >= 500));
      chk("start speed", {16'h0, FIXED_RPM}, {16'h0, speed_cmd});
      rq("start flag", REG_NORMAL, 32'h10, 32'h10);
      wait_spd(sref, 800);
      chk("start hold", 32'h1, 32'(k >= 560));
      chk("follow ref", {16'h0, sref}, {16'h0, speed_cmd});
      $display("test startup done");
      for (int i = 0; i < 5; i++) begin
         set_der(i, 1'b1);
         tick(6);
         rq("derate bit", REG_DERATE, 32'h75, 32'h1 << dpos[i]);
         rq("derate sum", REG_NORMAL, 32'h1000_0000, 32'h1000_0000);
         chk("slowed", (i < 3) ? {17'h0, sref[15:1]} : {16'h0, sref}, {16'h0, speed_cmd});
         chk("fan cut", {31'h0, i == 3}, {31'h0, fan_reduce});
         chk("power cap", {31'h0, i == 4}, {31'h0, pwr_limit});
         set_der(i, 1'b0);
         tick(6);
      end
      $display("test derating done");
      sens.speed_ref = 16'h07d0;
      wait_spd(16'h07d0, 20);
      wait_spd(FIXED_RPM, 18300);
      chk("oil delay", 32'h1, 32'(k >= 17900));
      rq("oil flag", REG_NORMAL, 32'h30, 32'h20);
      wait_spd(16'h07d0, 700);
      chk("oil hold", 32'h1, 32'(k >= 560));
      $display("test oil done");
      sens.evc_in_lost = 1'b1;
      tick(6);
      rq("valve lost", REG_SAFE, 32'hf, 32'h1);
      rq("safe sum", REG_NORMAL, 32'h2000_0000, 32'h2000_0000);
      chk("safe speed", {16'h0, FIXED_RPM}, {16'h0, speed_cmd});
      sens.evc_in_lost = 1'b0;
      tick(500);
      rq("valve held", REG_SAFE, 32'h1, 32'h1);
      tick(150);
      rq("valve free", REG_SAFE, 32'h1, 32'h0);
      sens.evc_out_lost = 1'b1;
      sens.amb_t = 11'sh065;
      tick(6);
      rq("two safe", REG_SAFE, 32'hf, 32'h6);
      rq("peripheral", REG_ALARM, 32'h1, 32'h1);
      chk("stopped", 32'h0, {31'h0, run_en});
      sens.evc_out_lost = 1'b0;
      sens.amb_t = 11'sh014;
      $display("test safe done");
      sens.dclink_v = 11'sh1c3;
      tick(6);
      rq("dc high", REG_ALARM, 32'h8, 32'h8);
      rq("alarm sum", REG_NORMAL, 32'h4000_0000, 32'h4000_0000);
      sens.supply_v = 11'sh0aa;
      tick(6);
      rq("under volt", REG_ALARM, 32'h20, 32'h20);
      sens.supply_v = 11'sh0e6;
      sens.dclink_v = 11'sh12c;
      tick(1100);
      rq("dc held", REG_ALARM, 32'h8, 32'h8);
      tick(200);
      rq("dc free", REG_ALARM, 32'h8, 32'h0);
      $display("test alarm done");
      sens.drive_t = 11'sh074;
      tick(6);
      rq("drive hot", REG_ALARM, 32'h10, 32'h10);
      sens.drive_t = 11'sh028;
      rst = 1'b1;
      tick(6);
      rst = 1'b0;
      tick(5);
      rq("lock kept", REG_NORMAL, 32'h8000_0000, 32'h8000_0000);
      u_m.xfer(1'b1, REG_REBOOT, 32'h1);
      tick(5);
      rq("lock gone", REG_NORMAL, 32'h8000_0000, 32'h0);
      $display("test trip done");
      u_m.xfer(1'b1, REG_TIMEOUT, 32'h5);
      tick(70);
      rq("read late", REG_ALARM, 32'h100, 32'h100);
      u_m.xfer(1'b1, REG_TIMEOUT, 32'h0);
      tick(5);
      rq("comm held", REG_ALARM, 32'h100, 32'h100);
      tick(1300);
      rq("check off", REG_ALARM, 32'h100, 32'h0);
      tick(5);
      chk("notes left", 32'h0, 32'(nq.size()));
      $display("test timeout done");
      report_and_stop();
   end
endmodule
